// [rtl/uwv_ctrl.v]
// Local design decisions: register access over AXI4-Lite and the address map.
`timescale 1ns/100ps
`include "uwv_defs.vh"
module uwv_ctrl (
   // Clock and reset
   input  wire        ref_clk,
   input  wire        sys_rst,
   // AXI4-Lite slave
   input  wire [11:0] s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [11:0] s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   // PHY and bus indications (asynchronous)
   input  wire        phy_id,
   input  wire        phy_vbus_valid,
   input  wire        phy_a_sess_valid,
   input  wire        phy_b_sess_valid,
   input  wire        phy_sess_end,
   input  wire        bus_event,
   input  wire        bus_resume,
   input  wire        bus_suspended,
   input  wire        bus_activity,
   // Outputs to controller
   output reg         usb_id,
   output reg         vbus_valid,
   output reg         a_sess_valid,
   output reg         b_sess_valid,
   output reg         sess_end,
   output reg         event_irq,
   output reg         resume_irq,
   output reg         wake_req
);
   // Two-stage synchronisers for all nine asynchronous inputs
   wire [8:0] async_in = {bus_activity, bus_suspended, bus_resume, bus_event, phy_sess_end,
                          phy_b_sess_valid, phy_a_sess_valid, phy_vbus_valid, phy_id};
   reg  [8:0] sync1_reg;
   reg  [8:0] sync2_reg;
   always @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         sync1_reg <= 9'h000;
         sync2_reg <= 9'h000;
      end else begin
         sync1_reg <= async_in;
         sync2_reg <= sync1_reg;
      end
   end
   wire s_id   = sync2_reg[0];
   wire s_vbus = sync2_reg[1];
   wire s_asv  = sync2_reg[2];
   wire s_bsv  = sync2_reg[3];
   wire s_send = sync2_reg[4];
   wire s_evt  = sync2_reg[5];
   wire s_res  = sync2_reg[6];
   wire s_susp = sync2_reg[7];
   wire s_act  = sync2_reg[8];

   // Registers
   reg  [`UWV_CTRL_W-1:0] ctrl_reg;
   reg  [`UWV_CTRL_W-1:0] ctrl_next;
   reg                    act_reg;
   reg                    act_next;
   reg                    act_prev_reg;
   reg                    aw_hold_reg;
   reg                    w_hold_reg;
   reg  [11:0]            awaddr_reg;
   reg  [31:0]            wdata_reg;
   reg  [3:0]             wstrb_reg;

   // Event and resume flags follow live conditions, so no separate clear is needed
   wire evt_flag = s_evt & ctrl_reg[`UWV_BIT_EVENT_IE];
   wire res_flag = s_res & s_susp;
   // Edge detector starts at the idle level of the pin, so reset gives no false edge
   wire act_rise = s_act & ~act_prev_reg;

   // Word decode shared by the write and read channels
   function addr_hit;
      input [11:0] a;
      begin
         addr_hit = (a[11:2] == `UWV_CTRL_IDX);
      end
   endfunction

   function [31:0] read_word;
      input [`UWV_CTRL_W-1:0] c;
      input                   a;
      input                   e;
      input                   r;
      begin
         read_word = 32'h0000_0000;
         read_word[`UWV_BIT_EVENT]    = e;
         read_word[`UWV_BIT_RESUME]   = r;
         read_word[`UWV_BIT_ACTIVITY] = a;
         read_word[`UWV_BIT_RSVD_ONE] = 1'b1;
         read_word[`UWV_CTRL_W-1:0]   = c;
      end
   endfunction

   // Write channel: address and data taken in either order
   assign s_axi_awready = ~aw_hold_reg & ~s_axi_bvalid;
   assign s_axi_wready  = ~w_hold_reg & ~s_axi_bvalid;
   wire aw_ok = aw_hold_reg | (s_axi_awvalid & s_axi_awready);
   wire w_ok  = w_hold_reg | (s_axi_wvalid & s_axi_wready);
   wire [11:0] wr_addr = aw_hold_reg ? awaddr_reg : s_axi_awaddr;
   wire [31:0] wr_data = w_hold_reg ? wdata_reg : s_axi_wdata;
   wire [3:0]  wr_strb = w_hold_reg ? wstrb_reg : s_axi_wstrb;
   wire do_write = aw_ok & w_ok & ~s_axi_bvalid;
   wire hit_w    = addr_hit(wr_addr);
   wire hit_r    = addr_hit(s_axi_araddr);

   assign s_axi_arready = ~s_axi_rvalid;

   // Write address is parked until its data arrives
   always @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         aw_hold_reg <= 1'b0;
         awaddr_reg  <= 12'h000;
      end else begin
         if (do_write) begin
            aw_hold_reg <= 1'b0;
         end else if (s_axi_awvalid & s_axi_awready) begin
            aw_hold_reg <= 1'b1;
         end
         if (s_axi_awvalid & s_axi_awready) begin
            awaddr_reg <= s_axi_awaddr;
         end
      end
   end

   // Write data is parked until its address arrives
   always @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         w_hold_reg <= 1'b0;
         wdata_reg  <= 32'h0000_0000;
         wstrb_reg  <= 4'h0;
      end else begin
         if (do_write) begin
            w_hold_reg <= 1'b0;
         end else if (s_axi_wvalid & s_axi_wready) begin
            w_hold_reg <= 1'b1;
         end
         if (s_axi_wvalid & s_axi_wready) begin
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
         end
      end
   end

   // Write response; both readies stay low until it is accepted
   always @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= 2'b00;
      end else begin
         if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= hit_w ? `UWV_RESP_OKAY : `UWV_RESP_SLVERR;
         end else if (s_axi_bvalid & s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Control bits; lane 2 has no storage and lane 3 holds only the activity bit below
   always @* begin
      ctrl_next = ctrl_reg;
      if (do_write & hit_w & wr_strb[0]) begin
         ctrl_next[7:0] = wr_data[7:0];
      end
      if (do_write & hit_w & wr_strb[1]) begin
         ctrl_next[9:8] = wr_data[9:8];
      end
   end

   // Writing a one to bit 24 leaves it alone; a set in the same cycle wins
   always @* begin
      act_next = act_reg;
      if (act_rise) begin
         act_next = 1'b1;
      end else if (do_write & hit_w & wr_strb[3] & ~wr_data[`UWV_BIT_ACTIVITY]) begin
         act_next = 1'b0;
      end
   end

   always @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl_reg     <= `UWV_CTRL_RST;
         act_reg      <= `UWV_ACT_RST;
         act_prev_reg <= 1'b0;
      end else begin
         ctrl_reg     <= ctrl_next;
         act_reg      <= act_next;
         act_prev_reg <= s_act;
      end
   end

   // Read channel; flags are sampled live when the address is taken
   always @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rresp  <= 2'b00;
         s_axi_rdata  <= 32'h0000_0000;
      end else begin
         if (s_axi_arvalid & s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            if (hit_r) begin
               s_axi_rdata <= read_word(ctrl_reg, act_reg, evt_flag, res_flag);
               s_axi_rresp <= `UWV_RESP_OKAY;
            end else begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= `UWV_RESP_SLVERR;
            end
         end else if (s_axi_rvalid & s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // Gated copies toward the controller, registered below
   reg                    usb_id_next;
   reg                    vbus_next;
   reg                    a_sess_next;
   reg                    b_sess_next;
   reg                    sess_end_next;
   reg                    event_next;
   reg                    resume_next;
   reg                    wake_next;
   always @* begin
      if (ctrl_reg[`UWV_BIT_ID_OVR_EN]) begin
         usb_id_next = ctrl_reg[`UWV_BIT_ID_OVR_VAL];
      end else begin
         usb_id_next = s_id & ctrl_reg[`UWV_BIT_PHY_ID_EN];
      end
      vbus_next     = s_vbus & ctrl_reg[`UWV_BIT_VBUS_EN];
      a_sess_next   = s_asv & ctrl_reg[`UWV_BIT_ASESS_EN];
      b_sess_next   = s_bsv & ctrl_reg[`UWV_BIT_BSESS_EN];
      sess_end_next = s_send & ctrl_reg[`UWV_BIT_SEND_EN];
      event_next    = evt_flag;
      resume_next   = res_flag & ctrl_reg[`UWV_BIT_RESUME_IE];
      wake_next     = act_reg & ctrl_reg[`UWV_BIT_WAKE_EN];
   end

   // Registered outputs toward the controller
   always @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         usb_id       <= 1'b0;
         vbus_valid   <= 1'b0;
         a_sess_valid <= 1'b0;
         b_sess_valid <= 1'b0;
         sess_end     <= 1'b0;
         event_irq    <= 1'b0;
         resume_irq   <= 1'b0;
         wake_req     <= 1'b0;
      end else begin
         usb_id       <= usb_id_next;
         vbus_valid   <= vbus_next;
         a_sess_valid <= a_sess_next;
         b_sess_valid <= b_sess_next;
         sess_end     <= sess_end_next;
         event_irq    <= event_next;
         resume_irq   <= resume_next;
         wake_req     <= wake_next;
      end
   end
endmodule // uwv_ctrl

// [rtl/uwv_defs.vh]
`ifndef UWV_DEFS_VH
`define UWV_DEFS_VH
// Register byte address (no offset documented)
`define UWV_CTRL_ADDR        12'h000
`define UWV_CTRL_IDX         10'h000
// Field positions
`define UWV_BIT_EVENT        26
`define UWV_BIT_RESUME       25
`define UWV_BIT_ACTIVITY     24
`define UWV_BIT_RSVD_ONE     15
`define UWV_BIT_ID_OVR_EN    9
`define UWV_BIT_ID_OVR_VAL   8
`define UWV_BIT_PHY_ID_EN    7
`define UWV_BIT_VBUS_EN      6
`define UWV_BIT_ASESS_EN     5
`define UWV_BIT_BSESS_EN     4
`define UWV_BIT_SEND_EN      3
`define UWV_BIT_EVENT_IE     2
`define UWV_BIT_RESUME_IE    1
`define UWV_BIT_WAKE_EN      0
// Writable control bits 9:0 and reset values
`define UWV_CTRL_W           10
`define UWV_CTRL_RST         10'h000
`define UWV_ACT_RST          1'b1
// AXI responses
`define UWV_RESP_OKAY        2'b00
`define UWV_RESP_SLVERR      2'b10
`endif

// [sim/uwv_phy_model.sv]
`timescale 1ns/100ps
module uwv_phy_model (
   // Clock and requested levels
   input wire       ref_clk,
   input wire [8:0] want,
   input wire       slow,
   // Levels seen by the block
   output reg [8:0] lvl
);
   reg [8:0] lag_reg;
   initial lvl = 9'h000;
   // Slow mode lags one more cycle, like a sluggish comparator
   always @(posedge ref_clk) begin
      lag_reg <= want;
      lvl <= slow ? lag_reg : want;
   end
endmodule // uwv_phy_model

// [sim/uwv_ctrl_checker.sv]
`timescale 1ns/100ps
module uwv_ctrl_chk (
   // Clock, reset and read channel
   input wire        ref_clk,
   input wire        sys_rst,
   input wire        s_axi_arvalid,
   input wire        s_axi_arready,
   input wire        s_axi_rvalid,
   input wire [31:0] s_axi_rdata,
   // Levels in and out
   input wire        phy_vbus_valid,
   input wire        vbus_valid,
   input wire        phy_a_sess_valid,
   input wire        a_sess_valid,
   input wire        phy_b_sess_valid,
   input wire        b_sess_valid,
   input wire        phy_sess_end,
   input wire        sess_end,
   input wire        bus_event,
   input wire        event_irq,
   input wire        bus_resume,
   input wire        bus_suspended,
   input wire        resume_irq
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   sequence s_ar; s_axi_arvalid && s_axi_arready; endsequence
   property p_rd; s_ar |=> s_axi_rvalid; endproperty
   a_rd: assert property (p_rd) else $error("read answer missing");
   property p_rv; $rose(s_axi_rvalid) |-> $past(s_axi_arvalid && s_axi_arready); endproperty
   a_rv: assert property (p_rv) else $error("read answer without request");
   property p_fld; s_axi_rvalid |-> !(s_axi_rdata & 32'hf8ff7c00)
      && (s_axi_rdata[15] || s_axi_rdata == 32'h0); endproperty
   a_fld: assert property (p_fld) else $error("fixed bits wrong");
   property p_vb; vbus_valid |-> $past(phy_vbus_valid, 3); endproperty
   a_vb: assert property (p_vb) else $error("vbus valid unfounded");
   property p_as; a_sess_valid |-> $past(phy_a_sess_valid, 3); endproperty
   a_as: assert property (p_as) else $error("a session unfounded");
   property p_bs; b_sess_valid |-> $past(phy_b_sess_valid, 3); endproperty
   a_bs: assert property (p_bs) else $error("b session unfounded");
   property p_se; sess_end |-> $past(phy_sess_end, 3); endproperty
   a_se: assert property (p_se) else $error("session end unfounded");
   property p_ev; event_irq |-> $past(bus_event, 3); endproperty
   a_ev: assert property (p_ev) else $error("event request unfounded");
   property p_rs; resume_irq |-> $past(bus_resume, 3) && $past(bus_suspended, 3); endproperty
   a_rs: assert property (p_rs) else $error("resume request unfounded");
endmodule // uwv_ctrl_chk
bind uwv_ctrl uwv_ctrl_chk i_uwv_ctrl_chk (.*);

// [sim/uwv_ctrl_bench.sv]
`timescale 1ns/100ps
module uwv_ctrl_bench;
   reg ref_clk = 0, sys_rst = 1, slow = 0, act = 0, prev = 0, aw_p = 0, w_p = 0;
   reg s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0, s_axi_bready = 1, s_axi_rready = 1;
   reg [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   reg [31:0] s_axi_wdata = 0, d;
   reg [3:0] s_axi_wstrb = 0;
   reg [8:0] want = 0;
   wire [8:0] lvl;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire usb_id, vbus_valid, a_sess_valid, b_sess_valid, sess_end, event_irq, resume_irq, wake_req;
   wire phy_id, phy_vbus_valid, phy_a_sess_valid, phy_b_sess_valid, phy_sess_end;
   wire bus_event, bus_resume, bus_suspended, bus_activity;
   integer n_fail = 0, n_checks = 0, seed = 51, i;
   assign {phy_id, phy_vbus_valid, phy_a_sess_valid, phy_b_sess_valid, phy_sess_end, bus_event,
      bus_resume, bus_suspended, bus_activity} = lvl;
   uwv_phy_model i_uwv_phy_model (.*);
   uwv_ctrl i_uwv_ctrl (.*);
   initial forever #20 ref_clk = ~ref_clk;
   function [31:0] exp_reg(input [9:0] c, input [8:0] p, input a);
      exp_reg = {5'h00, p[3] & c[2], p[2] & p[1], a, 8'h00, 1'b1, 5'h00, c};
   endfunction
   function [7:0] exp_out(input [9:0] c, input [8:0] p, input a);
      exp_out = {c[9] ? c[8] : p[8] & c[7], p[7:3] & c[6:2], p[2] & p[1] & c[1], a & c[0]};
   endfunction
   task chk(input [31:0] s, input [31:0] e);
      n_checks = n_checks + 1;
      if (s !== e) begin
         n_fail = n_fail + 1;
         $display("mismatch t=%0t seen %h exp %h", $time, s, e);
      end
   endtask
   // Both channels go out together; the slave raises both readies when idle
   task wr(input [11:0] a, input [31:0] v, input [3:0] s, input [1:0] r);
      {s_axi_awaddr, s_axi_wdata, s_axi_wstrb, s_axi_awvalid, s_axi_wvalid} <= {a, v, s, 2'b11};
      {aw_p, w_p} = 2'b11;
      while (aw_p || w_p) begin
         @(posedge ref_clk);
         if (aw_p && s_axi_awready) begin
            aw_p = 1'b0;
            s_axi_awvalid <= 1'b0;
         end
         if (w_p && s_axi_wready) begin
            w_p = 1'b0;
            s_axi_wvalid <= 1'b0;
         end
      end
      do @(posedge ref_clk); while (!s_axi_bvalid);
      chk(s_axi_bresp, r);
   endtask
   task rd(input [11:0] a, input [31:0] v, input [1:0] r);
      {s_axi_araddr, s_axi_arvalid} <= {a, 1'b1};
      do @(posedge ref_clk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge ref_clk); while (!s_axi_rvalid);
      chk(s_axi_rdata, v);
      chk(s_axi_rresp, r);
   endtask
   task give_verdict;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      repeat (3000) @(posedge ref_clk);
      n_fail = n_fail + 1;
      give_verdict;
   end
   initial begin
      repeat (2) @(posedge ref_clk);
      sys_rst <= 1'b0;
      @(posedge ref_clk);
      rd(12'h000, 32'h01008000, 2'h0);
      wr(12'h000, 32'hffffffff, 4'hf, 2'h0);
      rd(12'h000, 32'h010083ff, 2'h0);
      wr(12'h000, 32'h00000000, 4'h8, 2'h0);
      rd(12'h000, 32'h000083ff, 2'h0);
      wr(12'h004, 32'h00000000, 4'hf, 2'h2);
      rd(12'h004, 32'h00000000, 2'h2);
      $display("register tests done");
      for (i = 0; i < 40; i = i + 1) begin
         d = $random(seed);
         {want, slow} <= {d[24:16], d[31]};
         wr(12'h000, d, {d[30], 3'h3}, 2'h0);
         repeat (6) @(posedge ref_clk);
         @(negedge ref_clk);
         if (d[30] && !d[24]) act = 1'b0;
         if (d[16] && !prev) act = 1'b1;
         prev = d[16];
         chk({usb_id, vbus_valid, a_sess_valid, b_sess_valid, sess_end, event_irq, resume_irq,
            wake_req}, exp_out(d[9:0], d[24:16], act));
         @(posedge ref_clk);
         rd(12'h000, exp_reg(d[9:0], d[24:16], act), 2'h0);
      end
      $display("random tests done");
      want <= 9'h000;
      repeat (6) @(posedge ref_clk);
      sys_rst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      sys_rst <= 1'b0;
      @(posedge ref_clk);
      rd(12'h000, 32'h01008000, 2'h0);
      $display("reset tests done");
      give_verdict;
   end
endmodule // uwv_ctrl_bench
